// ==== mlb_defines.svh ====
`ifndef MLB_DEFINES_SVH
`define MLB_DEFINES_SVH
// port width codes
`define MLB_PW_32        2'h0
`define MLB_PW_16        2'h1
`define MLB_PW_8         2'h2
// datum size codes
`define MLB_SZ_BYTE      2'h0
`define MLB_SZ_HALF      2'h1
`define MLB_SZ_WORD      2'h2
// reset configuration bit positions on the low address pins
`define MLB_CFG_BOOT16   0
`define MLB_CFG_BOOT8    1
`define MLB_CFG_RSVDHI   2
`define MLB_CFG_EXTHOLD  3
// burst length in words
`define MLB_BURST_WORDS  3'h4
// strobes inactive (active low)
`define MLB_STROBES_OFF  4'hf
`endif

// ==== mlb_pkg.sv ====
`default_nettype none
package mlb_pkg;
   typedef enum logic [2:0] {
      MLB_IDLE,
      MLB_ADDR,
      MLB_SLOT2,
      MLB_DATA,
      MLB_DONE
   } mlb_state_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        write;
      logic        burst;
      logic [1:0]  size;
      logic        big_endian;
      logic        miss;
      logic        instr;
   } mlb_req_t;

   typedef struct packed {
      logic boot_rom_16bit_option;
      logic boot_rom_8bit_option;
      logic reserved_high_option;
      logic extended_address_hold_option;
   } mlb_cfg_t;
endpackage : mlb_pkg
`default_nettype wire

// ==== mlb_local_bus.sv ====
`include "mlb_defines.svh"
`default_nettype none
module mlb_local_bus (
   // clock and reset
   input  wire logic            core_clk,
   input  wire logic            reset,
   // core side request
   input  wire logic            req_valid,
   input  var  mlb_pkg::mlb_req_t req,
   output logic                 req_ready,
   // memory port configuration
   input  wire logic [1:0]      port_width,
   input  wire logic            system_control_coprocessor_strobe_hold,
   // external acknowledge of one datum
   input  wire logic            data_ack,
   // shared address/data bus
   input  wire logic [31:0]     ad_in,
   output logic [31:0]          ad_out,
   output logic                 ad_oe,
   // low address pins
   input  wire logic [3:0]      low_addr_in,
   output logic [3:0]           low_addr_out,
   output logic                 low_addr_oe,
   // strobes and diagnostic pin
   output logic                 addr_latch_en,
   output logic                 diag,
   // read buffer and configuration
   output logic [31:0]          rd_data,
   output logic                 rd_valid,
   output var  mlb_pkg::mlb_cfg_t cfg
);
   ////////////////////////////////////////////////////////////////////////////
   // byte lane decode, used only for the strobes; read data is taken from the bus unshifted
   function automatic logic [3:0] lane_mask(input logic [1:0] size,
                                            input logic [1:0] a,
                                            input logic       be);
      logic [1:0] l;
      l = be ? ~a : a;
      lane_mask = 4'h0;
      if (size == `MLB_SZ_WORD) begin
         lane_mask = 4'hf;
      end else if (size == `MLB_SZ_HALF) begin
         lane_mask = (be ? ~a[1] : a[1]) ? 4'hc : 4'h3;
      end else begin
         lane_mask = 4'h1 << l;
      end
   endfunction : lane_mask

   function automatic logic [3:0] port_step(input logic [1:0] pw);
      if (pw == `MLB_PW_32) begin
         port_step = 4'h4;
      end else if (pw == `MLB_PW_16) begin
         port_step = 4'h2;
      end else begin
         port_step = 4'h1;
      end
   endfunction : port_step

   ////////////////////////////////////////////////////////////////////////////
   mlb_pkg::mlb_state_t state_q, state_d;
   mlb_pkg::mlb_req_t   cur_q, cur_d;
   logic [3:0]  laddr_q, laddr_d, end_q, end_d;
   logic [2:0]  beats_q, beats_d;
   logic [31:0] ad_q, ad_d, rd_q, rd_d;
   logic        oe_q, oe_d, loe_q, loe_d, ale_q, ale_d, diag_q, diag_d;
   logic        rdy_q, rdy_d, rv_q, rv_d, cfg_take_q;
   mlb_pkg::mlb_cfg_t cfg_q, cfg_d;
   logic [3:0]  nxt_addr, lanes;

   always_comb begin
      state_d  = state_q;
      cur_d    = cur_q;
      laddr_d  = laddr_q;
      end_d    = end_q;
      beats_d  = beats_q;
      ad_d     = ad_q;
      rd_d     = rd_q;
      oe_d     = oe_q;
      loe_d    = loe_q;
      ale_d    = 1'b0;
      diag_d   = diag_q;
      rdy_d    = 1'b0;
      rv_d     = 1'b0;
      cfg_d    = cfg_q;
      nxt_addr = laddr_q + port_step(port_width);
      lanes    = lane_mask(cur_q.size, cur_q.addr[1:0], cur_q.big_endian);
      // straps are taken once; later traffic on these pins never disturbs them
      if (cfg_take_q) begin
         cfg_d = {low_addr_in[`MLB_CFG_BOOT16], low_addr_in[`MLB_CFG_BOOT8],
                  low_addr_in[`MLB_CFG_RSVDHI], low_addr_in[`MLB_CFG_EXTHOLD]};
      end
      case (state_q)
         mlb_pkg::MLB_IDLE: begin
            oe_d  = 1'b0;
            // ready does not wait on valid; a request held over reset would else lock up
            rdy_d = 1'b1;
            if (req_valid && rdy_q) begin
               cur_d   = req;
               rdy_d   = 1'b0;
               state_d = mlb_pkg::MLB_ADDR;
            end
         end
         mlb_pkg::MLB_ADDR: begin
            // strobes are driven regardless of width; narrow ports simply ignore them
            ad_d[31:4] = cur_q.addr[31:4];
            ad_d[3:0]  = ~lanes;
            if (!cur_q.write && system_control_coprocessor_strobe_hold) begin
               ad_d[3:0] = `MLB_STROBES_OFF;
            end
            oe_d    = 1'b1;
            ale_d   = 1'b1;
            diag_d  = cur_q.miss;
            loe_d   = 1'b1;
            beats_d = cur_q.burst ? `MLB_BURST_WORDS : 3'h1;
            if (cur_q.burst && !cur_q.write) begin
               laddr_d = 4'h0;
               end_d   = 4'h0;
            end else begin
               laddr_d = cur_q.addr[3:0];
               end_d   = cur_q.addr[3:0] + ((cur_q.size == `MLB_SZ_WORD) ? 4'h4 :
                         (cur_q.size == `MLB_SZ_HALF) ? 4'h2 : 4'h1);
            end
            state_d = mlb_pkg::MLB_SLOT2;
         end
         mlb_pkg::MLB_SLOT2: begin
            diag_d  = cur_q.instr;
            oe_d    = cur_q.write;
            ad_d    = cur_q.wdata;
            state_d = mlb_pkg::MLB_DATA;
         end
         mlb_pkg::MLB_DATA: begin
            if (data_ack) begin
               if (!cur_q.write) begin
                  rd_d = ad_in;
                  rv_d = 1'b1;
               end
               laddr_d = nxt_addr;
               // a read burst counts words, so narrow ports take several acks per word
               if (cur_q.burst && !cur_q.write) begin
                  if (nxt_addr[1:0] == 2'h0) begin
                     beats_d = beats_q - 3'h1;
                     if (beats_q == 3'h1) begin
                        state_d = mlb_pkg::MLB_DONE;
                     end
                  end
               end else if (nxt_addr == end_q ||
                            port_width == `MLB_PW_32) begin
                  state_d = mlb_pkg::MLB_DONE;
               end
            end
         end
         default: begin
            oe_d    = 1'b0;
            rdy_d   = 1'b1;
            state_d = mlb_pkg::MLB_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_q    <= mlb_pkg::MLB_IDLE;
         cur_q      <= '0;
         laddr_q    <= 4'h0;
         end_q      <= 4'h0;
         beats_q    <= 3'h0;
         ad_q       <= 32'h0;
         rd_q       <= 32'h0;
         oe_q       <= 1'b0;
         loe_q      <= 1'b0;   // pins are inputs while reset holds
         ale_q      <= 1'b0;
         diag_q     <= 1'b0;
         rdy_q      <= 1'b0;
         rv_q       <= 1'b0;
         cfg_q      <= '0;
         cfg_take_q <= 1'b1;
      end else begin
         state_q    <= state_d;
         cur_q      <= cur_d;
         laddr_q    <= laddr_d;
         end_q      <= end_d;
         beats_q    <= beats_d;
         ad_q       <= ad_d;
         rd_q       <= rd_d;
         oe_q       <= oe_d;
         loe_q      <= loe_d;
         ale_q      <= ale_d;
         diag_q     <= diag_d;
         rdy_q      <= rdy_d;
         rv_q       <= rv_d;
         cfg_q      <= cfg_d;
         cfg_take_q <= 1'b0;   // straps caught on first edge after release
      end
   end

   assign ad_out        = ad_q;
   assign ad_oe         = oe_q;
   assign low_addr_out  = laddr_q;
   assign low_addr_oe   = loe_q;
   assign addr_latch_en = ale_q;
   assign diag          = diag_q;
   assign req_ready     = rdy_q;
   assign rd_data       = rd_q;
   assign rd_valid      = rv_q;
   assign cfg           = cfg_q;
endmodule : mlb_local_bus
`default_nettype wire

// ==== mlb_local_bus_sva.sv ====
`default_nettype none
module mlb_chk (
   // watched ports
   input wire logic              core_clk,
   input wire logic              reset,
   input wire logic              req_valid,
   input var  mlb_pkg::mlb_req_t req,
   input wire logic              req_ready,
   input wire logic [1:0]        port_width,
   input wire logic              system_control_coprocessor_strobe_hold,
   input wire logic              data_ack,
   input wire logic [31:0]       ad_out,
   input wire logic              ad_oe,
   input wire logic [3:0]        low_addr_out,
   input wire logic              addr_latch_en,
   input wire logic              diag,
   input wire logic              rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   sequence take_s;
      req_valid && req_ready;
   endsequence
   sequence rd_take_s;
      take_s ##0 !req.write;
   endsequence
   AST_ALE_ONE: assert property (addr_latch_en |=> !addr_latch_en)
      else $error("latch strobe longer than one cycle");
   AST_ADDR_HI: assert property (take_s |-> ##2 addr_latch_en && ad_oe &&
         ad_out[31:4] == $past(req.addr[31:4], 2))
      else $error("upper address missing in address phase");
   AST_STB_HOLD: assert property (rd_take_s ##0 system_control_coprocessor_strobe_hold
         |-> ##2 ad_out[3:0] == 4'hf)
      else $error("strobes not held off on read");
   AST_LANES: assert property (take_s ##0 req.write && req.size == 2'h2 &&
         port_width == 2'h0 |-> ##2 ad_out[3:0] == 4'h0)
      else $error("word write lanes wrong");
   AST_LANE_BYTE: assert property (rd_take_s ##0 req.size == 2'h0 &&
         !req.big_endian && !system_control_coprocessor_strobe_hold |->
         ##2 ad_out[3:0] == ~(4'h1 << $past(req.addr[1:0], 2)))
      else $error("byte read lane strobe wrong");
   AST_DIAG: assert property (rd_take_s |-> ##2 diag == $past(req.miss, 2)
         ##1 diag == $past(req.instr, 3))
      else $error("diagnostic pin wrong");
   AST_WDATA: assert property (take_s ##0 req.write |->
         ##3 ad_oe && ad_out == $past(req.wdata, 3))
      else $error("store data not driven");
   AST_LOW_TGT: assert property (take_s ##0 (req.write || !req.burst) |->
         ##2 low_addr_out == $past(req.addr[3:0], 2))
      else $error("low address not target");
   AST_LOW_BURST: assert property (rd_take_s ##0 req.burst |-> ##2 low_addr_out == 4'h0)
      else $error("burst count not from zero");
   AST_RD_ACK: assert property (rd_valid |-> $past(data_ack))
      else $error("read datum without acknowledge");
endmodule : mlb_chk
bind mlb_local_bus mlb_chk chk_u (.core_clk, .reset, .req_valid, .req, .req_ready, .port_width,
   .system_control_coprocessor_strobe_hold, .data_ack, .ad_out, .ad_oe, .low_addr_out,
   .addr_latch_en, .diag, .rd_valid);
`default_nettype wire

// ==== mlb_mem_model.sv ====
`default_nettype none
module mlb_mem_model (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // device pins
   input  wire logic [31:0] ad_out,
   input  wire logic        ad_oe,
   input  wire logic [3:0]  low_addr_out,
   input  wire logic        low_addr_oe,
   input  wire logic        addr_latch_en,
   // answers
   output logic [31:0]      ad_in,
   output logic [3:0]       low_addr_in,
   output logic             data_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [27:0] lat_q;
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         data_ack <= 1'b0;
         lat_q <= 28'h0;
      end else begin
         // every other cycle: acknowledges alternate, so successive datums within one transfer are two cycles apart
         data_ack <= ~data_ack;
         // strobes are never latched, so narrow ports cannot misuse them
         if (addr_latch_en) begin
            lat_q <= ad_out[31:4];
         end
      end
   end
   // datum carries its own low address; a driven bus shows the inverse, not a copy
   assign ad_in = ad_oe ? ~ad_out : {lat_q[23:0], 4'h0, low_addr_out};
   assign low_addr_in = low_addr_oe ? ~low_addr_out : 4'h5;
endmodule : mlb_mem_model
`default_nettype wire

// ==== tb.sv ====
`include "mlb_defines.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, reset, req_valid, req_ready, hold, data_ack, ad_oe;
   logic low_addr_oe, addr_latch_en, diag, rd_valid;
   logic [1:0]  port_width;
   logic [31:0] ad_in, ad_out, rd_data, first_q;
   logic [3:0]  low_addr_in, low_addr_out;
   mlb_pkg::mlb_req_t req;
   mlb_pkg::mlb_cfg_t cfg;
   int fail_count, n_checks, n_rd;
   mlb_local_bus dut_u (.core_clk, .reset, .req_valid, .req, .req_ready, .port_width,
      .system_control_coprocessor_strobe_hold(hold), .data_ack, .ad_in, .ad_out, .ad_oe,
      .low_addr_in, .low_addr_out, .low_addr_oe, .addr_latch_en, .diag, .rd_data,
      .rd_valid, .cfg);
   mlb_mem_model mem_u (.core_clk, .reset, .ad_out, .ad_oe, .low_addr_out, .low_addr_oe,
      .addr_latch_en, .ad_in, .low_addr_in, .data_ack);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   task automatic xfer(input logic [31:0] a, input logic w, b, input logic [1:0] sz, pw,
                       input int n, input logic [3:0] s);
      int i;
      @(negedge core_clk);
      port_width = pw;
      req = '{a, ~a, w, b, sz, a[5], a[6], a[4]};
      req_valid = 1'b1;
      for (i = 0; i < 50 && req_ready !== 1'b1; i++)
         @(negedge core_clk);
      if (i == 50) begin
         fail_count++;
         wrap_up();
      end
      @(negedge core_clk);
      req_valid = 1'b0;
      n_rd = 0;
      for (i = 0; i < 100; i++) begin
         @(negedge core_clk);
         if (rd_valid === 1'b1) begin
            if (n_rd == 0)
               first_q = rd_data;
            n_rd++;
         end
         if (req_ready === 1'b1)
            break;
      end
      if (i == 100) begin
         fail_count++;
         wrap_up();
      end
      @(negedge core_clk);
      if (rd_valid === 1'b1)
         n_rd++;
      chk("datums", n_rd, n);
      if (n > 0)
         chk("first datum", first_q, {a[27:4], 4'h0, s});
   endtask : xfer
   ////////////////////////////////////////////////////////////////////////////////
   task automatic sc_single();
      xfer(32'h0000_abc3, 1'b0, 1'b0, `MLB_SZ_BYTE, `MLB_PW_8, 1, 4'h3);
      xfer(32'h0000_abc6, 1'b0, 1'b0, `MLB_SZ_HALF, `MLB_PW_8, 2, 4'h6);
      hold = 1'b1;
      xfer(32'h0001_2368, 1'b0, 1'b0, `MLB_SZ_WORD, `MLB_PW_16, 2, 4'h8);
      xfer(32'h0001_2354, 1'b0, 1'b0, `MLB_SZ_WORD, `MLB_PW_32, 1, 4'h4);
      hold = 1'b0;
   endtask : sc_single
   task automatic sc_write();
      xfer(32'h1234_5670, 1'b1, 1'b0, `MLB_SZ_WORD, `MLB_PW_32, 0, 4'h0);
      xfer(32'h1234_5672, 1'b1, 1'b0, `MLB_SZ_HALF, `MLB_PW_8, 0, 4'h0);
      chk("bus released", ad_oe, 32'h0);
      chk("low pins driven", low_addr_oe, 32'h1);
   endtask : sc_write
   task automatic sc_burst();
      for (int pw = 0; pw < 3; pw++)
         xfer(32'h0abc_de1c, 1'b0, 1'b1, `MLB_SZ_WORD, 2'(pw), 4 << pw, 4'h0);
   endtask : sc_burst
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      reset = 1'b1;
      req_valid = 1'b0;
      req = '0;
      port_width = 2'h0;
      hold = 1'b0;
      fail_count = 0;
      n_checks = 0;
      repeat (12) @(negedge core_clk);
      chk("pins during reset", low_addr_oe, 32'h0);
      reset = 1'b0;
      repeat (2) @(negedge core_clk);
      chk("cfg", cfg, 32'ha);
      sc_single();
      sc_write();
      sc_burst();
      wrap_up();
   end
endmodule : tb
`default_nettype wire
